// ==== rtl/sats_consts.svh ====
// constants for the shared adc trigger and scan sequencer
`ifndef SATS_CONSTS_SVH
`define SATS_CONSTS_SVH
`define SATS_N_INPUTS        12
`define SATS_N_FIRST         8
`define SATS_TRG_W           5
`define SATS_SAMPLE_TIME_COUNT_W          10
`define SATS_TRG_NONE        5'h00
`define SATS_TRG_GSW         5'h01
`define SATS_TRG_GLSW        5'h02
`define SATS_TRG_SCAN        5'h03
`define SATS_ADDR_W          4
`define SATS_A_CTRL1         4'h0
`define SATS_A_CTRL2         4'h1
`define SATS_A_TRG_LO        4'h2
`define SATS_A_TRG_HI        4'h3
`define SATS_A_SCAN          4'h4
`define SATS_A_MODE          4'h5
`define SATS_A_SWTRG         4'h6
`define SATS_A_STATUS        4'h7
`define SATS_A_READY         4'h8
`define SATS_SCAN_SRC_LSB    16
`define SATS_SAMPLE_TIME_COUNT_LSB        16
`define SATS_GSW_BIT         6
`define SATS_GLSW_BIT        7
`define SATS_TRG_STRIDE      8
`define SATS_SIGN_OFS        1
`define SATS_RST_SAMPLE_TIME_COUNT        10'h001
`endif

// ==== rtl/sats_pkg.sv ====
// types for the shared adc trigger and scan sequencer
`default_nettype none
package sats_pkg;
  typedef enum logic [1:0] {
    SATS_IDLE   = 2'b00,
    SATS_SAMPLE = 2'b01,
    SATS_CONV   = 2'b11
  } sats_state_t;
  typedef struct packed {
    logic       connect;
    logic [3:0] input_sel;
    logic       differential;
    logic       signed_mode;
  } sats_mux_t;
endpackage
`default_nettype wire

// ==== rtl/sats_prio.sv ====
// lowest-numbered-first priority picker
`include "sats_consts.svh"
`default_nettype none
module sats_prio #(
  parameter int N = `SATS_N_INPUTS
) (
  input  wire logic [N-1:0]         req,
  output logic                      any,
  output logic [$clog2(N)-1:0]      idx
);
  initial begin
    if (N < 2) begin
      $error("sats_prio needs at least two inputs");
    end
  end
  // scan from the top so the lowest set bit wins
  always_comb begin
    any = |req;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = ($clog2(N))'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/sats_seq.sv ====
// trigger arbitration and sample/convert sequencing for one shared adc
`include "sats_consts.svh"
`default_nettype none
module sats_seq #(
  parameter int N      = `SATS_N_INPUTS,
  parameter int NFIRST = `SATS_N_FIRST,
  parameter int SAMPLE_TIME_COUNT_W = `SATS_SAMPLE_TIME_COUNT_W
) (
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  input  wire logic [`SATS_ADDR_W-1:0]    reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_write,
  input  wire logic                       reg_read,
  output logic      [31:0]                reg_rdata,
  input  wire logic [31:0]                trigger_in,
  output sats_pkg::sats_mux_t             mux_ctrl,
  output logic                            conv_start,
  input  wire logic                       conv_done,
  input  wire logic [11:0]                conv_raw,
  output logic      [15:0]                result_data,
  output logic                            result_valid,
  output logic      [3:0]                 result_input
);
  localparam int IW = $clog2(N);

  initial begin
    if (N != `SATS_N_INPUTS || NFIRST != `SATS_N_FIRST) begin
      $error("sats_seq supports twelve inputs with eight first-class");
    end
    if (SAMPLE_TIME_COUNT_W < 1 || SAMPLE_TIME_COUNT_W > 16) begin
      $error("sats_seq sample count width out of range");
    end
  end

  // registers
  logic [4:0]           scan_trigger_select_q;
  logic [SAMPLE_TIME_COUNT_W-1:0]    sample_time_count_q;
  logic [NFIRST*5-1:0]  input_trigger_select_q;
  logic [N-1:0]         scan_input_select_q;
  logic [N-1:0]         differential_select_q;
  logic [N-1:0]         signed_select_q;
  logic                 gsw_pulse_q;
  logic                 glsw_level_q;
  logic [N-1:0]         ready_q;
  logic [N-1:0]         pend_q;
  logic [N-1:0]         scan_pend_q;
  logic [SAMPLE_TIME_COUNT_W-1:0]    cnt_q;
  logic [IW-1:0]        cur_q;
  logic                 cur_scan_q;
  logic [31:0]          trg_prev_q;
  sats_pkg::sats_state_t state_q;

  // decode a trigger source code into an event this cycle
  function automatic logic src_event(input logic [4:0] code,
                                     input logic [31:0] rise,
                                     input logic gsw, input logic glsw);
    logic ev;
    ev = 1'b0;
    case (code)
      `SATS_TRG_NONE: ev = 1'b0;
      `SATS_TRG_GSW:  ev = gsw;
      `SATS_TRG_GLSW: ev = glsw;
      `SATS_TRG_SCAN: ev = 1'b0;
      default:        ev = rise[code];
    endcase
    return ev;
  endfunction

  // software register writes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scan_trigger_select_q  <= `SATS_TRG_NONE;
      sample_time_count_q    <= SAMPLE_TIME_COUNT_W'(`SATS_RST_SAMPLE_TIME_COUNT);
      input_trigger_select_q <= '0;
      scan_input_select_q    <= '0;
      differential_select_q  <= '0;
      signed_select_q        <= '0;
      glsw_level_q           <= 1'b0;
    end else if (reg_write) begin
      case (reg_addr)
        `SATS_A_CTRL1: scan_trigger_select_q <=
          reg_wdata[`SATS_SCAN_SRC_LSB +: 5];
        `SATS_A_CTRL2: sample_time_count_q <=
          reg_wdata[`SATS_SAMPLE_TIME_COUNT_LSB +: SAMPLE_TIME_COUNT_W];
        `SATS_A_TRG_LO: for (int i = 0; i < 4; i++) begin
          input_trigger_select_q[i*5 +: 5] <=
            reg_wdata[i*`SATS_TRG_STRIDE +: 5];
        end
        `SATS_A_TRG_HI: for (int i = 0; i < 4; i++) begin
          input_trigger_select_q[(i+4)*5 +: 5] <=
            reg_wdata[i*`SATS_TRG_STRIDE +: 5];
        end
        `SATS_A_SCAN: scan_input_select_q <= reg_wdata[N-1:0];
        `SATS_A_MODE: for (int i = 0; i < N; i++) begin
          differential_select_q[i] <= reg_wdata[2*i];
          signed_select_q[i] <= reg_wdata[2*i+`SATS_SIGN_OFS];
        end
        `SATS_A_SWTRG: glsw_level_q <= reg_wdata[`SATS_GLSW_BIT];
        default: ;
      endcase
    end
  end

  // self-clearing global software trigger
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gsw_pulse_q <= 1'b0;
    end else begin
      gsw_pulse_q <= reg_write && reg_addr == `SATS_A_SWTRG &&
                     reg_wdata[`SATS_GSW_BIT];
    end
  end

  // hardware trigger edge detect
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trg_prev_q <= '0;
    end else begin
      trg_prev_q <= trigger_in;
    end
  end

  logic [31:0]   trg_rise;
  logic [N-1:0]  indiv_ev;
  logic          scan_ev;
  logic [N-1:0]  scan_members;
  assign trg_rise = trigger_in & ~trg_prev_q;

  // per-input individual events and scan membership
  always_comb begin
    indiv_ev     = '0;
    scan_members = scan_input_select_q;
    scan_ev      = src_event(scan_trigger_select_q, trg_rise,
                             gsw_pulse_q, glsw_level_q);
    for (int i = 0; i < NFIRST; i++) begin
      indiv_ev[i] = src_event(input_trigger_select_q[i*5 +: 5], trg_rise,
                              gsw_pulse_q, glsw_level_q);
      if (input_trigger_select_q[i*5 +: 5] != `SATS_TRG_SCAN) begin
        scan_members[i] = 1'b0;
      end
    end
  end

  // merged request vector: individual and scan pending ranked by input number alone
  logic [N-1:0] all_req;
  logic         pick_any;
  logic [IW-1:0] pick_idx;
  assign all_req = pend_q | scan_pend_q;

  sats_prio #(
    .N (N)
  ) u_prio (
    .req (all_req),
    .any (pick_any),
    .idx (pick_idx)
  );

  logic start_next;
  logic finishing;
  logic preempt;
  assign finishing  = state_q == sats_pkg::SATS_CONV && conv_done;
  assign start_next = pick_any &&
                      (state_q == sats_pkg::SATS_IDLE || finishing);
  // an individual trigger of lower number than the scan sample preempts
  assign preempt = state_q == sats_pkg::SATS_SAMPLE && cur_scan_q &&
                   pick_any && pick_idx < cur_q &&
                   pend_q[pick_idx];

  // pending individual requests; new event wins over service clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend_q <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (indiv_ev[i]) begin
          pend_q[i] <= 1'b1;
        end else if ((start_next || preempt) && pick_idx == IW'(i) &&
                     pend_q[i]) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // pending scan members; class two and three only through scan
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scan_pend_q <= '0;
    end else if (scan_ev) begin
      scan_pend_q <= scan_members;
    end else if (preempt) begin
      scan_pend_q[cur_q] <= 1'b1;
    end else if (start_next && !pend_q[pick_idx]) begin
      scan_pend_q[pick_idx] <= 1'b0;
    end
  end

  // sample and convert sequence
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q    <= sats_pkg::SATS_IDLE;
      cnt_q      <= '0;
      cur_q      <= '0;
      cur_scan_q <= 1'b0;
    end else begin
      case (state_q)
        sats_pkg::SATS_IDLE: begin
          if (start_next) begin
            state_q    <= sats_pkg::SATS_SAMPLE;
            cnt_q      <= sample_time_count_q;
            cur_q      <= pick_idx;
            cur_scan_q <= !pend_q[pick_idx];
          end
        end
        sats_pkg::SATS_SAMPLE: begin
          if (preempt) begin
            cnt_q      <= sample_time_count_q;
            cur_q      <= pick_idx;
            cur_scan_q <= 1'b0;
          end else if (cnt_q <= SAMPLE_TIME_COUNT_W'(1)) begin
            state_q <= sats_pkg::SATS_CONV;
          end else begin
            cnt_q <= cnt_q - SAMPLE_TIME_COUNT_W'(1);
          end
        end
        sats_pkg::SATS_CONV: begin
          if (conv_done) begin
            if (start_next) begin
              state_q    <= sats_pkg::SATS_SAMPLE;
              cnt_q      <= sample_time_count_q;
              cur_q      <= pick_idx;
              cur_scan_q <= !pend_q[pick_idx];
            end else begin
              state_q <= sats_pkg::SATS_IDLE;
            end
          end
        end
        default: state_q <= sats_pkg::SATS_IDLE;
      endcase
    end
  end

  // conversion start pulse on leaving sampling
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= state_q == sats_pkg::SATS_SAMPLE && !preempt &&
                    cnt_q <= SAMPLE_TIME_COUNT_W'(1);
    end
  end

  // front end mux control follows the active input
  always_comb begin
    mux_ctrl.connect      = state_q != sats_pkg::SATS_IDLE;
    mux_ctrl.input_sel    = 4'(cur_q);
    mux_ctrl.differential = differential_select_q[cur_q];
    mux_ctrl.signed_mode  = signed_select_q[cur_q];
  end

  // result capture and sign handling
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result_data  <= '0;
      result_valid <= 1'b0;
      result_input <= '0;
    end else begin
      result_valid <= finishing;
      if (finishing) begin
        result_input <= 4'(cur_q);
        if (signed_select_q[cur_q]) begin
          // offset binary to two's complement, sign extended
          result_data <= {{4{~conv_raw[11]}}, ~conv_raw[11],
                          conv_raw[10:0]};
        end else begin
          result_data <= {4'h0, conv_raw};
        end
      end
    end
  end

  // result-ready flags; completion wins over a read clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ready_q <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (finishing && cur_q == IW'(i)) begin
          ready_q[i] <= 1'b1;
        end else if (reg_read && reg_addr == `SATS_A_READY) begin
          ready_q[i] <= 1'b0;
        end
      end
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= '0;
      case (reg_addr)
        `SATS_A_CTRL1: reg_rdata[`SATS_SCAN_SRC_LSB +: 5] <=
          scan_trigger_select_q;
        `SATS_A_CTRL2: reg_rdata[`SATS_SAMPLE_TIME_COUNT_LSB +: SAMPLE_TIME_COUNT_W] <=
          sample_time_count_q;
        `SATS_A_TRG_LO: for (int i = 0; i < 4; i++) begin
          reg_rdata[i*`SATS_TRG_STRIDE +: 5] <=
            input_trigger_select_q[i*5 +: 5];
        end
        `SATS_A_TRG_HI: for (int i = 0; i < 4; i++) begin
          reg_rdata[i*`SATS_TRG_STRIDE +: 5] <=
            input_trigger_select_q[(i+4)*5 +: 5];
        end
        `SATS_A_SCAN: reg_rdata[N-1:0] <= scan_input_select_q;
        `SATS_A_MODE: for (int i = 0; i < N; i++) begin
          reg_rdata[2*i] <= differential_select_q[i];
          reg_rdata[2*i+`SATS_SIGN_OFS] <= signed_select_q[i];
        end
        `SATS_A_SWTRG: reg_rdata[`SATS_GLSW_BIT] <= glsw_level_q;
        // only first-class inputs can hold an individual request
        `SATS_A_STATUS: reg_rdata <= {2'(state_q), 2'h0, 4'(cur_q),
                                      cur_scan_q, 3'h0, scan_pend_q,
                                      pend_q[NFIRST-1:0]};
        `SATS_A_READY: reg_rdata[N-1:0] <= ready_q;
        default: reg_rdata <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== bench/sats_seq_chk.sv ====
// assertion checker on the ports of the adc trigger and scan sequencer
`default_nettype none
module sats_seq_chk #(
  parameter int N = 12
) (
  input wire logic                ref_clk,
  input wire logic                reset,
  input wire logic [3:0]          reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_write,
  input wire logic                reg_read,
  input wire logic [31:0]         reg_rdata,
  input wire logic [31:0]         trigger_in,
  input wire sats_pkg::sats_mux_t mux_ctrl,
  input wire logic                conv_start,
  input wire logic                conv_done,
  input wire logic [11:0]         conv_raw,
  input wire logic [15:0]         result_data,
  input wire logic                result_valid,
  input wire logic [3:0]          result_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_q;
  // marks a conversion handed to the converter and not yet done
  always_ff @(posedge ref_clk) begin
    if (reset) busy_q <= 1'b0;
    else if (conv_start) busy_q <= 1'b1;
    else if (conv_done) busy_q <= 1'b0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conv_start longer than one cycle");
  a_start_connected: assert property (conv_start |-> mux_ctrl.connect)
    else $error("conversion started with no input connected");
  a_idle_no_start: assert property (!mux_ctrl.connect |-> !conv_start)
    else $error("conversion started while disconnected");
  a_done_result: assert property (
    busy_q && conv_done |=> result_valid ##1 !result_valid)
    else $error("result pulse missing after conversion");
  a_no_stray: assert property (
    result_valid |-> $past(conv_done) && $past(busy_q))
    else $error("result without a finished conversion");
  a_result_input: assert property (
    busy_q && conv_done |=> result_input == $past(mux_ctrl.input_sel))
    else $error("result tagged with wrong input");
  a_result_unsigned: assert property (
    busy_q && conv_done && !mux_ctrl.signed_mode
    |=> result_data == {4'h0, $past(conv_raw)})
    else $error("unsigned result wrong");
  a_result_signed: assert property (
    busy_q && conv_done && mux_ctrl.signed_mode
    |=> result_data == {{5{~$past(conv_raw[11])}}, $past(conv_raw[10:0])})
    else $error("signed result wrong");
  a_conv_hold: assert property (
    busy_q && !conv_done |=> $stable(mux_ctrl))
    else $error("front end changed during conversion");
  a_sel_range: assert property (
    mux_ctrl.connect |-> mux_ctrl.input_sel < 4'(N))
    else $error("input number out of range");
  // main scenarios
  c_signed: cover property (busy_q && conv_done && mux_ctrl.signed_mode);
  c_connect: cover property ($rose(mux_ctrl.connect));
  c_last_scan: cover property (conv_start && mux_ctrl.input_sel == 4'hb);
endmodule
bind sats_seq sats_seq_chk #(.N(N)) u_sats_seq_chk (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .trigger_in(trigger_in), .mux_ctrl(mux_ctrl),
  .conv_start(conv_start), .conv_done(conv_done), .conv_raw(conv_raw),
  .result_data(result_data), .result_valid(result_valid),
  .result_input(result_input));
`default_nettype wire

// ==== bench/sats_conv_model.sv ====
// behavioural converter core facing the sequencer
`default_nettype none
module sats_conv_model (
  input  wire logic                ref_clk,
  input  wire logic                reset,
  input  wire logic                slow,
  input  wire sats_pkg::sats_mux_t mux_ctrl,
  input  wire logic                conv_start,
  output logic                     conv_done,
  output logic [11:0]              conv_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic [3:0] sel_q;
  // converts the held input; the code carries the input number
  always @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= 4'h0;
      conv_done <= 1'b0;
      conv_raw <= 12'h000;
    end else begin
      conv_done <= 1'b0;
      conv_raw <= ~conv_raw; // no valid code outside the done pulse
      if (conv_start) begin
        cnt_q <= slow ? 4'h6 : 4'h1;
        sel_q <= mux_ctrl.input_sel;
      end else if (cnt_q == 4'h1) begin
        cnt_q <= 4'h0;
        conv_done <= 1'b1;
        conv_raw <= {sel_q, 8'h3c};
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb_sats_seq.sv ====
// self-checking bench for the adc trigger and scan sequencer
`default_nettype none
`define CHK(nm, x, g) begin \
  num_checks++; \
  if ((g) !== (x)) begin \
    n_errors++; \
    $display("ERROR %s exp %h got %h", nm, x, g); \
  end \
end
module tb_sats_seq;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk = 1'b0;
  logic                reset = 1'b1;
  logic [3:0]          reg_addr = 4'h0;
  logic [31:0]         reg_wdata = 32'h0;
  logic                reg_write = 1'b0;
  logic                reg_read = 1'b0;
  logic [31:0]         trigger_in = 32'h0;
  logic                slow = 1'b0;
  logic [31:0]         reg_rdata;
  sats_pkg::sats_mux_t mux_ctrl;
  logic                conv_start;
  logic                conv_done;
  logic [11:0]         conv_raw;
  logic [15:0]         result_data;
  logic                result_valid;
  logic [3:0]          result_input;
  logic [31:0]         rv;
  logic [23:0]         mode;
  logic [15:0]         lfsr = 16'h745b;
  logic [19:0]         exp_q[$];
  logic [19:0]         e;
  int                  n_errors = 0;
  int                  num_checks = 0;
  always #5 ref_clk = ~ref_clk;
  sats_seq u_sats_seq (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .trigger_in(trigger_in),
    .mux_ctrl(mux_ctrl), .conv_start(conv_start), .conv_done(conv_done),
    .conv_raw(conv_raw), .result_data(result_data),
    .result_valid(result_valid), .result_input(result_input));
  sats_conv_model u_sats_conv_model (.ref_clk(ref_clk), .reset(reset),
    .slow(slow), .mux_ctrl(mux_ctrl), .conv_start(conv_start),
    .conv_done(conv_done), .conv_raw(conv_raw));
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // expected input number and result for input i
  function automatic logic [19:0] expv(input int i);
    logic [11:0] r;
    r = {4'(i), 8'h3c};
    return {4'(i), mode[2*i+1] ? {{5{~r[11]}}, r[10:0]} : {4'h0, r}};
  endfunction
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [31:0] x);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 rv = reg_rdata;
    `CHK("reg_rdata", x, rv)
  endtask
  task automatic pulse(input int b);
    @(posedge ref_clk);
    trigger_in[b] <= 1'b1;
    @(posedge ref_clk);
    trigger_in[b] <= 1'b0;
  endtask
  // waits for every expected result, then two cycles, and checks that the front end has let go
  task automatic drain;
    int k;
    for (k = 0; k < 3000 && exp_q.size() != 0; k++) @(posedge ref_clk);
    if (k == 3000) begin
      n_errors++;
      $display("ERROR drain exp 0 got %0d", exp_q.size());
      finish_test();
    end
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("connect", 1'b0, mux_ctrl.connect)
  endtask
  // compares each result with the oldest expectation
  always @(negedge ref_clk) begin
    if (result_valid === 1'b1) begin
      e = (exp_q.size() == 0) ? 20'hfffff : exp_q.pop_front();
      `CHK("result_input", e[19:16], result_input)
      `CHK("result_data", e[15:0], result_data)
    end
  end
  initial begin
    int k;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    chk_rd(4'h1, 32'h0001_0000);
    chk_rd(4'hf, 32'h0);
    lfsr = lfsr_next(lfsr);
    mode[15:0] = lfsr;
    lfsr = lfsr_next(lfsr);
    mode[23:16] = lfsr[7:0];
    wr(4'h5, {8'h0, mode});
    wr(4'h2, 32'h0105_0404);
    wr(4'h3, 32'h0000_0300);
    wr(4'h4, 32'h0000_0f20);
    wr(4'h1, 32'h0003_0000);
    chk_rd(4'h2, 32'h0105_0404);
    // in0 and in1 on one edge, in2 arrives while in0 is busy
    for (k = 0; k < 3; k++) exp_q.push_back(expv(k));
    pulse(4);
    pulse(5);
    drain();
    chk_rd(4'h8, 32'h0000_0007);
    chk_rd(4'h8, 32'h0);
    exp_q.push_back(expv(3));
    wr(4'h6, 32'h0000_0040);
    drain();
    chk_rd(4'h8, 32'h0000_0008);
    // scan of in5 and in8..11, in2 cuts in while in8 samples
    wr(4'h1, 32'h0028_0000);
    wr(4'h0, 32'h0006_0000);
    slow <= 1'b1;
    exp_q.push_back(expv(5));
    exp_q.push_back(expv(2));
    for (k = 8; k < 12; k++) exp_q.push_back(expv(k));
    pulse(6);
    for (k = 0; k < 2000 && !(mux_ctrl.connect === 1'b1 &&
         mux_ctrl.input_sel === 4'h8); k++) @(posedge ref_clk);
    `CHK("scan_wait", 1'b1, k < 2000)
    if (k == 2000) finish_test();
    `CHK("differential", mode[16], mux_ctrl.differential)
    `CHK("signed_mode", mode[17], mux_ctrl.signed_mode)
    pulse(5);
    drain();
    chk_rd(4'h8, 32'h0000_0f24);
    finish_test();
  end
endmodule
`default_nettype wire
